// >>> design/eprg_map.vh
// Constants, pin level encodings and timing counts for the cell programmer
// Notes on behaviour
// - Byte on data, supply high, then strobe low
// - No write while select or strobe high
// - Erase, program, verify, protect, verify protect; no erase step here, the cell is assumed erased
// - Zero unused locations before protecting; not done here, bytes past last_word are left as they are
// - First pulse 0.95-1.05 ms or 95-105 us
// - Distinct pin levels per mode; protect on top bit
`ifndef EPRG_MAP_VH
`define EPRG_MAP_VH
// Counts at 100 MHz, sized to the counter: 1 ms, 100 us, 2 us
`define EPRG_PULSE_FAST_CYC  17'h186a0
`define EPRG_PULSE_SHORT_CYC 17'h02710
`define EPRG_SETUP_CYC       17'h000c8
`define EPRG_CNT_W   17
`define EPRG_TRY_W   5
`define EPRG_MAX_TRY 5'h19
`define EPRG_WORDS_AW 12
`define EPRG_ADDR_W  13
`define EPRG_DATA_W  8
`define EPRG_WORD_W  16
`define EPRG_PROT_BIT 7
`define EPRG_PROT_ADDR 13'h0010
`define EPRG_BLANK   8'hff
`define EPRG_ZERO    8'h00
`define EPRG_LAST_WORD 12'hfff
`define EPRG_CNT_ONE 17'h00001
`define EPRG_CNT_ZERO 17'h00000
`endif

// >>> design/eprg_image_mem.v
// Program image store: 4K words, registered read
`timescale 1ns/1ps
`default_nettype none
`include "eprg_map.vh"
module eprg_image_mem (
	// Clock
	input  wire                      clock,
	// Load port
	input  wire                      wr_en,
	input  wire [`EPRG_WORDS_AW-1:0] wr_addr,
	input  wire [`EPRG_WORD_W-1:0]   wr_data,
	// Read port
	input  wire [`EPRG_WORDS_AW-1:0] rd_addr,
	output reg  [`EPRG_WORD_W-1:0]   rd_data
);
	reg [`EPRG_WORD_W-1:0] mem [0:(1<<`EPRG_WORDS_AW)-1];
	always @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // eprg_image_mem
`default_nettype wire

// >>> design/eprg_programmer.v
// Programmer that burns a stored word image into the cell and protects it
`timescale 1ns/1ps
`default_nettype none
`include "eprg_map.vh"
module eprg_programmer (
	// Clock and reset
	input  wire                      clock,
	input  wire                      resetn,
	// Image load
	input  wire                      load_en,
	input  wire [`EPRG_WORDS_AW-1:0] load_addr,
	input  wire [`EPRG_WORD_W-1:0]   load_data,
	// Control
	input  wire                      start,
	input  wire                      short_pulse,
	input  wire                      do_protect,
	input  wire [`EPRG_WORDS_AW-1:0] last_word,
	output reg                       busy,
	output reg                       done,
	output reg                       fail,
	output reg  [`EPRG_ADDR_W-1:0]   fail_addr,
	// Cell pins
	output reg  [`EPRG_ADDR_W-1:0]   cell_addr,
	input  wire [`EPRG_DATA_W-1:0]   data_in,
	output reg  [`EPRG_DATA_W-1:0]   data_out,
	output reg                       data_oe,
	output reg                       chip_select_n,
	output reg                       output_enable_n,
	output reg                       program_strobe_n,
	output reg                       vpp_high,
	output reg                       cell_test_select
);
	localparam S_IDLE  = 8'h01;
	localparam S_SETUP = 8'h02;
	localparam S_PULSE = 8'h04;
	localparam S_VSET  = 8'h08;
	localparam S_VCHK  = 8'h10;
	localparam S_PSET  = 8'h20;
	localparam S_PPUL  = 8'h40;
	localparam S_PCHK  = 8'h80;

	reg [7:0]                  state;
	reg [`EPRG_CNT_W-1:0]      cnt;
	reg [`EPRG_TRY_W-1:0]      tries;
	reg [`EPRG_ADDR_W-1:0]     baddr;
	reg [`EPRG_DATA_W-1:0]     din_s1;
	reg [`EPRG_DATA_W-1:0]     din_s2;
	reg                        short_sel;
	reg                        prot_sel;
	reg [`EPRG_WORDS_AW-1:0]   last_sel;
	wire [`EPRG_WORD_W-1:0]    word;
	wire [`EPRG_DATA_W-1:0]    want;
	wire [`EPRG_WORDS_AW-1:0]  widx;
	wire [`EPRG_CNT_W-1:0]     pulse_len;
	wire                       last_byte;

	assign widx = baddr[`EPRG_ADDR_W-1:1];
	// Even byte is high half of word
	assign want = baddr[0] ? word[`EPRG_DATA_W-1:0] : word[`EPRG_WORD_W-1:`EPRG_DATA_W];
	assign pulse_len = short_sel ? `EPRG_PULSE_SHORT_CYC : `EPRG_PULSE_FAST_CYC;
	assign last_byte = (widx == last_sel) && baddr[0];

	eprg_image_mem u_mem (
		.clock   (clock),
		.wr_en   (load_en & ~busy),
		.wr_addr (load_addr),
		.wr_data (load_data),
		.rd_addr (widx),
		.rd_data (word)
	);

	// Data pins are asynchronous to our clock
	always @(posedge clock) begin
		din_s1 <= data_in;
		din_s2 <= din_s1;
	end

	always @(posedge clock) begin
		if (!resetn) begin
			state <= S_IDLE;
			cnt <= `EPRG_CNT_ZERO;
			tries <= {`EPRG_TRY_W{1'b0}};
			baddr <= {`EPRG_ADDR_W{1'b0}};
			short_sel <= 1'b0;
			prot_sel <= 1'b0;
			last_sel <= `EPRG_LAST_WORD;
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			fail_addr <= {`EPRG_ADDR_W{1'b0}};
			cell_addr <= {`EPRG_ADDR_W{1'b0}};
			data_out <= `EPRG_ZERO;
			data_oe <= 1'b0;
			chip_select_n <= 1'b1;
			output_enable_n <= 1'b1;
			program_strobe_n <= 1'b1;
			vpp_high <= 1'b0;
			cell_test_select <= 1'b0;
		end else begin
			case (state)
			S_IDLE: begin
				chip_select_n <= 1'b1;
				program_strobe_n <= 1'b1;
				output_enable_n <= 1'b1;
				data_oe <= 1'b0;
				vpp_high <= 1'b0;
				cell_test_select <= 1'b0;
				if (start) begin
					// Assumes a fully erased cell; blank bytes read all ones
					short_sel <= short_pulse;
					prot_sel <= do_protect;
					// Zero fill of unused words needs last word fff and a zeroed image
					last_sel <= last_word;
					baddr <= {`EPRG_ADDR_W{1'b0}};
					tries <= {`EPRG_TRY_W{1'b0}};
					cnt <= `EPRG_CNT_ZERO;
					busy <= 1'b1;
					done <= 1'b0;
					fail <= 1'b0;
					state <= S_SETUP;
				end
			end
			S_SETUP: begin
				// Byte and supply settle before the strobe falls
				cell_addr <= baddr;
				data_out <= want;
				data_oe <= 1'b1;
				vpp_high <= 1'b1;
				chip_select_n <= 1'b0;
				output_enable_n <= 1'b1;
				cnt <= cnt + `EPRG_CNT_ONE;
				if (cnt == `EPRG_SETUP_CYC) begin
					cnt <= `EPRG_CNT_ZERO;
					program_strobe_n <= 1'b0;
					state <= S_PULSE;
				end
			end
			S_PULSE: begin
				cnt <= cnt + `EPRG_CNT_ONE;
				if (cnt == pulse_len - `EPRG_CNT_ONE) begin
					cnt <= `EPRG_CNT_ZERO;
					program_strobe_n <= 1'b1;
					tries <= tries + 1'b1;
					state <= S_VSET;
				end
			end
			S_VSET: begin
				// Verify: strobe high, output enable low, we release data
				data_oe <= 1'b0;
				output_enable_n <= 1'b0;
				cnt <= cnt + `EPRG_CNT_ONE;
				if (cnt == `EPRG_SETUP_CYC) begin
					cnt <= `EPRG_CNT_ZERO;
					state <= S_VCHK;
				end
			end
			S_VCHK: begin
				output_enable_n <= 1'b1;
				if (din_s2 == want) begin
					tries <= {`EPRG_TRY_W{1'b0}};
					if (last_byte) begin
						state <= prot_sel ? S_PSET : S_IDLE;
						busy <= prot_sel;
						done <= ~prot_sel;
					end else begin
						baddr <= baddr + 1'b1;
						state <= S_SETUP;
					end
				end else if (tries == `EPRG_MAX_TRY) begin
					fail <= 1'b1;
					fail_addr <= baddr;
					busy <= 1'b0;
					state <= S_IDLE;
				end else begin
					state <= S_SETUP;
				end
			end
			S_PSET: begin
				// Protect: select high, test select at supply, pulse top data line
				chip_select_n <= 1'b1;
				cell_test_select <= 1'b1;
				vpp_high <= 1'b1;
				cell_addr <= `EPRG_PROT_ADDR;
				data_oe <= 1'b1;
				data_out <= `EPRG_BLANK;
				cnt <= cnt + `EPRG_CNT_ONE;
				if (cnt == `EPRG_SETUP_CYC) begin
					cnt <= `EPRG_CNT_ZERO;
					data_out[`EPRG_PROT_BIT] <= 1'b0;
					state <= S_PPUL;
				end
			end
			S_PPUL: begin
				cnt <= cnt + `EPRG_CNT_ONE;
				if (cnt == pulse_len - `EPRG_CNT_ONE) begin
					cnt <= `EPRG_CNT_ZERO;
					data_out <= `EPRG_BLANK;
					data_oe <= 1'b0;
					chip_select_n <= 1'b0;
					// Protect verify runs at the lower supply
					vpp_high <= 1'b0;
					output_enable_n <= 1'b0;
					cell_addr <= {`EPRG_ADDR_W{1'b0}};
					tries <= tries + 1'b1;
					state <= S_PCHK;
				end
			end
			S_PCHK: begin
				cnt <= cnt + `EPRG_CNT_ONE;
				if (cnt == `EPRG_SETUP_CYC) begin
					cnt <= `EPRG_CNT_ZERO;
					// Programmed protect bit reads as zero
					if (!din_s2[`EPRG_PROT_BIT]) begin
						done <= 1'b1;
						busy <= 1'b0;
						state <= S_IDLE;
					end else if (tries == `EPRG_MAX_TRY) begin
						fail <= 1'b1;
						fail_addr <= `EPRG_PROT_ADDR;
						busy <= 1'b0;
						state <= S_IDLE;
					end else begin
						chip_select_n <= 1'b1;
						output_enable_n <= 1'b1;
						state <= S_PSET;
					end
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // eprg_programmer
`default_nettype wire

// >>> testbench/eprg_checker_props.sv
// Pin-level checks for the cell programmer
`timescale 1ns/1ps
`default_nettype none
module eprg_checker (
	// Clock and reset
	input wire logic        clock,
	input wire logic        resetn,
	// Control
	input wire logic        start,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        fail,
	// Cell pins
	input wire logic [12:0] cell_addr,
	input wire logic [7:0]  data_out,
	input wire logic        data_oe,
	input wire logic        chip_select_n,
	input wire logic        output_enable_n,
	input wire logic        program_strobe_n,
	input wire logic        vpp_high,
	input wire logic        cell_test_select
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	logic [16:0] low_cnt;
	// Length of the current strobe pulse
	always @(posedge clock) begin
		if (!resetn || program_strobe_n)
			low_cnt <= 17'h0;
		else
			low_cnt <= low_cnt + 17'h1;
	end
	a_pulse_width: assert property ($rose(program_strobe_n) |-> (low_cnt >= 17'h0251c && low_cnt <= 17'h02904)
		|| (low_cnt >= 17'h17318 && low_cnt <= 17'h19a28)) else $error("strobe pulse length off");
	a_strobe_qualified: assert property (!program_strobe_n |-> vpp_high && data_oe && !chip_select_n)
		else $error("strobe without supply, data or select");
	a_data_held: assert property ($fell(program_strobe_n) |-> $stable(data_out) && $stable(cell_addr))
		else $error("data or address moved at strobe");
	a_strobe_no_read: assert property (!program_strobe_n |-> output_enable_n)
		else $error("read enabled during strobe");
	a_no_contention: assert property (!output_enable_n |-> !data_oe)
		else $error("data driven while cell outputs");
	a_protect_addr: assert property (cell_test_select && chip_select_n && data_oe && !data_out[7] |-> cell_addr[4])
		else $error("protect pulse without address bit 4");
	a_idle_inhibit: assert property (!busy |-> program_strobe_n)
		else $error("strobe while idle");
	a_start_taken: assert property (start && !busy |=> busy)
		else $error("start not taken");
	a_one_outcome: assert property (!(done && fail))
		else $error("done and fail together");
	c_pulse: cover property ($rose(program_strobe_n));
	c_protect: cover property (cell_test_select && chip_select_n && !data_out[7]);
	c_done: cover property ($rose(done));
endmodule // eprg_checker
bind eprg_programmer eprg_checker i_chk (.clock(clock), .resetn(resetn), .start(start), .busy(busy), .done(done),
	.fail(fail), .cell_addr(cell_addr), .data_out(data_out), .data_oe(data_oe), .chip_select_n(chip_select_n),
	.output_enable_n(output_enable_n), .program_strobe_n(program_strobe_n), .vpp_high(vpp_high),
	.cell_test_select(cell_test_select));
`default_nettype wire

// >>> testbench/eprg_cell_model.sv
// Behavioural model of the byte-wide program cell
`timescale 1ns/1ps
`default_nettype none
module eprg_cell_model (
	// Clock
	input wire logic        clock,
	// Cell pins
	input wire logic [12:0] cell_addr,
	input wire logic [7:0]  data_out,
	input wire logic        data_oe,
	input wire logic        chip_select_n,
	input wire logic        output_enable_n,
	input wire logic        program_strobe_n,
	input wire logic        vpp_high,
	input wire logic        cell_test_select,
	output logic [7:0]      data_in
);
	logic [7:0] mem [0:8191];
	logic       prot;
	logic [7:0] junk;
	initial begin
		prot = 1'b0;
		junk = 8'h5a;
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'hff;
	end
	always @(posedge clock) begin
		junk <= junk + 8'h01;
		if (vpp_high && !program_strobe_n && !chip_select_n && data_oe && !cell_test_select)
			mem[cell_addr] <= mem[cell_addr] & data_out;
		if (vpp_high && cell_test_select && chip_select_n && data_oe && !data_out[7] && cell_addr[4])
			prot <= 1'b1;
	end
	// Released bus shows a moving pattern, never the last value
	assign data_in = (chip_select_n || output_enable_n || data_oe) ? junk :
		cell_test_select ? {~prot, 7'h7f} : prot ? junk : mem[cell_addr];
endmodule // eprg_cell_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the cell programmer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock, resetn, load_en, start, short_pulse, do_protect;
	logic [11:0] load_addr, last_word;
	logic [15:0] load_data;
	wire busy, done, fail, data_oe, cs_n, oe_n, strobe_n, vpp, tsel;
	wire [12:0] fail_addr, cell_addr;
	wire [7:0] data_in, data_out;
	int error_cnt = 0;
	int checks = 0;
	eprg_programmer i_dut (.clock(clock), .resetn(resetn), .load_en(load_en), .load_addr(load_addr),
		.load_data(load_data), .start(start), .short_pulse(short_pulse), .do_protect(do_protect),
		.last_word(last_word), .busy(busy), .done(done), .fail(fail), .fail_addr(fail_addr),
		.cell_addr(cell_addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.chip_select_n(cs_n), .output_enable_n(oe_n), .program_strobe_n(strobe_n), .vpp_high(vpp),
		.cell_test_select(tsel));
	eprg_cell_model i_cell (.clock(clock), .cell_addr(cell_addr), .data_out(data_out), .data_oe(data_oe),
		.chip_select_n(cs_n), .output_enable_n(oe_n), .program_strobe_n(strobe_n), .vpp_high(vpp),
		.cell_test_select(tsel), .data_in(data_in));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic wrap_up;
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic load(input logic [11:0] a, input logic [15:0] d);
		@(posedge clock);
		#1 load_en = 1'b1;
		load_addr = a;
		load_data = d;
		@(posedge clock);
		#1 load_en = 1'b0;
	endtask
	// Short pulses only: the long pulse would blow the run length
	task automatic run(input logic [11:0] lw, input logic prot);
		int n;
		@(posedge clock);
		#1 start = 1'b1;
		last_word = lw;
		do_protect = prot;
		@(posedge clock);
		#1 start = 1'b0;
		for (n = 0; n < 60000 && !(done === 1'b1 || fail === 1'b1); n++) begin
			@(posedge clock);
			#1;
		end
		if (n == 60000) begin
			error_cnt++;
			wrap_up();
		end else begin
			cmp("done", 8'h01, {7'h0, done});
			cmp("fail", 8'h00, {7'h0, fail});
			cmp("busy", 8'h00, {7'h0, busy});
		end
	endtask
	// Reset in the middle of a program pulse must drop every strobe at once
	task automatic scen_reset;
		@(posedge clock);
		#1 start = 1'b1;
		last_word = 12'h000;
		do_protect = 1'b0;
		@(posedge clock);
		#1 start = 1'b0;
		repeat (300) @(posedge clock);
		#1 resetn = 1'b0;
		@(posedge clock);
		#1;
		cmp("strobe in reset", 8'h01, {7'h0, strobe_n});
		cmp("select in reset", 8'h01, {7'h0, cs_n});
		cmp("busy in reset", 8'h00, {7'h0, busy});
		cmp("drive in reset", 8'h00, {7'h0, data_oe});
		cmp("supply in reset", 8'h00, {7'h0, vpp});
		@(posedge clock);
		#1 resetn = 1'b1;
		@(posedge clock);
		#1;
		cmp("strobe after reset", 8'h01, {7'h0, strobe_n});
		cmp("byte 0 after cut", 8'h12, i_cell.mem[0]);
	endtask
	task automatic scen_program;
		load(12'h000, 16'h1234);
		load(12'h001, 16'h5678);
		run(12'h001, 1'b0);
		cmp("byte 0", 8'h12, i_cell.mem[0]);
		cmp("byte 1", 8'h34, i_cell.mem[1]);
		cmp("byte 2", 8'h56, i_cell.mem[2]);
		cmp("byte 3", 8'h78, i_cell.mem[3]);
		cmp("byte 4", 8'hff, i_cell.mem[4]);
		cmp("protect", 8'h00, {7'h0, i_cell.prot});
	endtask
	task automatic scen_protect;
		load(12'h000, 16'h1230);
		run(12'h000, 1'b1);
		cmp("byte 1 again", 8'h30, i_cell.mem[1]);
		cmp("byte 2 kept", 8'h56, i_cell.mem[2]);
		cmp("protect", 8'h01, {7'h0, i_cell.prot});
	endtask
	initial begin
		resetn = 1'b0;
		load_en = 1'b0;
		start = 1'b0;
		short_pulse = 1'b1;
		do_protect = 1'b0;
		load_addr = 12'h000;
		last_word = 12'h000;
		load_data = 16'h0000;
		repeat (6) @(posedge clock);
		#1 resetn = 1'b1;
		scen_program();
		scen_protect();
		scen_reset();
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
